// *** disp_timing_cfg.svh ***
// Register offsets, field positions and reset values of the display timing generator.
// Assumes a 32-bit APB slave decoding byte addresses in an 8-bit window.
`ifndef DISP_TIMING_CFG_SVH
`define DISP_TIMING_CFG_SVH

`define OFF_CTRL 8'h00
`define OFF_DIV 8'h04
`define OFF_PIX 8'h08
`define OFF_HTOT 8'h0c
`define OFF_HSYNC 8'h10
`define OFF_HACT 8'h14
`define OFF_VTOT 8'h18
`define OFF_VSYNC 8'h1c
`define OFF_VACT 8'h20
`define OFF_SHIFT 8'h24
`define OFF_STAT 8'h28

`define CTRL_EN 0
`define FLD_LO 11:0
`define FLD_HI 27:16
`define FLD_WLO 15:0
`define FLD_WHI 31:16
`define DIV_INT 11:4
`define DIV_FRAC 3:0
`define SHF_CLK 7:0
`define SHF_STB 23:16
`define PIX_N 1:0

`define RST_DIVIDE 12'h020
`define RST_RATIO 12'h010
`define RST_PIXN 2'h0
`define RST_HTOT 12'h020
`define RST_HSW 12'h004
`define RST_HSOFF 12'h000
`define RST_HFRONT 12'h004
`define RST_HLEN 12'h010
`define RST_VTOT 12'h00c
`define RST_VSW 16'h0040
`define RST_VSOFF 16'h0000
`define RST_VFRONT 12'h002
`define RST_VLEN 12'h008
`define RST_CLKOFF 8'h00
`define RST_SHIFT 8'h00

`endif

// *** disp_timing_pkg.sv ***
// Types shared by the display timing generator.
// Assumes the constants of disp_timing_cfg.svh alongside.
package disp_timing_pkg;
   typedef logic [11:0] count_t;
   typedef logic [23:0] half_t;
   typedef logic [31:0] word_t;
   typedef logic [7:0] lane_t;
endpackage : disp_timing_pkg

// *** sync_tft_display_timing_gen.sv ***
// Timing generator for a synchronous TFT panel with an APB register file.
// Assumes one 40 MHz clock, a synchronous active-high reset and an
// external double-rate output cell that plays each 2-bit phase pair as
// first half then second half of the clock cycle.
//
// Summary of operation
// - Four panel controls beside the pixel bus.
// - All controls timed from the local start point.
// - Each access lasts whole internal clock cycles.
// - Pixel data changes only at start point.
// - Pixel bus is output only.
// - Pixel spans one to n display clocks.
// - Line total sets line sync spacing.
// - Line sync width in half-cycle units.
// - Front blanking, active width, then back blanking.
// - Frame total lines set frame sync spacing.
// - Front blank lines, active lines, back lines.
// - Frame sync width in half-cycle units.
// - Display clock edges offset by half cycles.
// - Line sync offset by half cycles.
// - Frame sync offset by half cycles.
// - Strobe offset from its data start point.
// - Divider resolution is one sixteenth cycle.
// - Fractional periods are floor or floor plus one.
// - Controls half-cycle, data whole-cycle granularity.
// - Divider and ratio held in writable registers.
// - Counters give offset, period and edge positions.
// - Start point synchronous; edges measured from it.
`include "disp_timing_cfg.svh"

module sync_tft_display_timing_gen (
   input wire logic clk, // Internal display clock, 40 MHz.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [31:0] pixIn, // Pixel word, component 0 in low byte.
   input wire logic pixValid, // Pixel word valid.
   output logic pixReady, // Pixel word taken this cycle.
   output logic [7:0] pixelData, // Panel data bus.
   output logic [1:0] dispClkPh, // Display clock, two half-cycle phases.
   output logic [1:0] lineSyncPh, // Line sync, two half-cycle phases.
   output logic [1:0] frameSyncPh, // Frame sync, two half-cycle phases.
   output logic [1:0] activePixelStrobePh // Active data strobe phases.
);

   // ==========================================================
   // Register file
   // ==========================================================
   logic en_r;
   logic [11:0] div_r;
   disp_timing_pkg::count_t clockRatioParam_r;
   logic [1:0] pixN_r;
   disp_timing_pkg::count_t hTot_r;
   disp_timing_pkg::count_t hsW_r;
   disp_timing_pkg::count_t hsOff_r;
   disp_timing_pkg::count_t lineFrontBlank_r;
   disp_timing_pkg::count_t activeLineLen_r;
   disp_timing_pkg::count_t vTot_r;
   logic [15:0] vsW_r;
   logic [15:0] vsOff_r;
   disp_timing_pkg::count_t frameFrontBlank_r;
   disp_timing_pkg::count_t activeFrameLines_r;
   logic [7:0] clkOff_r;
   logic [7:0] strobeShift_r;
   disp_timing_pkg::word_t prdata_r;

   // Timing state, declared here because the read mux shows it.
   logic [8:0] cyc_r;
   logic [8:0] len_r;
   logic [3:0] frac_r;
   logic [1:0] comp_r;
   disp_timing_pkg::count_t hcnt_r;
   disp_timing_pkg::count_t vcnt_r;
   disp_timing_pkg::half_t lineHalf_r;
   disp_timing_pkg::half_t frameHalf_r;
   logic actPrev_r;
   disp_timing_pkg::word_t word_r;
   disp_timing_pkg::lane_t pixelData_r;
   logic [1:0] clkPh_r;
   logic [1:0] hsPh_r;
   logic [1:0] vsPh_r;
   logic [1:0] stPh_r;
   logic actNow;

   wire hitCtrl = (paddr == `OFF_CTRL);
   wire hitDiv = (paddr == `OFF_DIV);
   wire hitPix = (paddr == `OFF_PIX);
   wire hitHtot = (paddr == `OFF_HTOT);
   wire hitHsync = (paddr == `OFF_HSYNC);
   wire hitHact = (paddr == `OFF_HACT);
   wire hitVtot = (paddr == `OFF_VTOT);
   wire hitVsync = (paddr == `OFF_VSYNC);
   wire hitVact = (paddr == `OFF_VACT);
   wire hitShift = (paddr == `OFF_SHIFT);
   wire hitStat = (paddr == `OFF_STAT);
   wire mapped = hitCtrl | hitDiv | hitPix | hitHtot | hitHsync | hitHact
      | hitVtot | hitVsync | hitVact | hitShift | hitStat;
   wire wrEn = psel & penable & pwrite & ce & mapped;
   wire setupRd = psel & ~penable & ~pwrite & ce;

   wire [31:0] rdMux =
      hitCtrl ? {31'h0000_0000, en_r} :
      hitDiv ? {4'h0, clockRatioParam_r, 4'h0, div_r} :
      hitPix ? {30'h0000_0000, pixN_r} :
      hitHtot ? {20'h0_0000, hTot_r} :
      hitHsync ? {4'h0, hsOff_r, 4'h0, hsW_r} :
      hitHact ? {4'h0, activeLineLen_r, 4'h0, lineFrontBlank_r} :
      hitVtot ? {20'h0_0000, vTot_r} :
      hitVsync ? {vsOff_r, vsW_r} :
      hitVact ? {4'h0, activeFrameLines_r, 4'h0, frameFrontBlank_r} :
      hitShift ? {8'h00, strobeShift_r, 8'h00, clkOff_r} :
      hitStat ? {actNow, 3'h0, vcnt_r, 4'h0, hcnt_r} :
      32'h0000_0000;

   // A frozen clock enable also stalls the bus by holding pready low.
   assign pready = ce;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_r;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (setupRd)
      begin
         prdata_r <= rdMux;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         en_r <= 1'b0;
         div_r <= `RST_DIVIDE;
         clockRatioParam_r <= `RST_RATIO;
         pixN_r <= `RST_PIXN;
         clkOff_r <= `RST_CLKOFF;
         strobeShift_r <= `RST_SHIFT;
      end
      else if (wrEn)
      begin
         if (hitCtrl) en_r <= pwdata[`CTRL_EN];
         if (hitDiv) div_r <= pwdata[`FLD_LO];
         if (hitDiv) clockRatioParam_r <= pwdata[`FLD_HI];
         if (hitPix) pixN_r <= pwdata[`PIX_N];
         if (hitShift) clkOff_r <= pwdata[`SHF_CLK];
         if (hitShift) strobeShift_r <= pwdata[`SHF_STB];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hTot_r <= `RST_HTOT;
         hsW_r <= `RST_HSW;
         hsOff_r <= `RST_HSOFF;
         lineFrontBlank_r <= `RST_HFRONT;
         activeLineLen_r <= `RST_HLEN;
         vTot_r <= `RST_VTOT;
         vsW_r <= `RST_VSW;
         vsOff_r <= `RST_VSOFF;
         frameFrontBlank_r <= `RST_VFRONT;
         activeFrameLines_r <= `RST_VLEN;
      end
      else if (wrEn)
      begin
         if (hitHtot) hTot_r <= pwdata[`FLD_LO];
         if (hitHsync) hsW_r <= pwdata[`FLD_LO];
         if (hitHsync) hsOff_r <= pwdata[`FLD_HI];
         if (hitHact) lineFrontBlank_r <= pwdata[`FLD_LO];
         if (hitHact) activeLineLen_r <= pwdata[`FLD_HI];
         if (hitVtot) vTot_r <= pwdata[`FLD_LO];
         if (hitVsync) vsW_r <= pwdata[`FLD_WLO];
         if (hitVsync) vsOff_r <= pwdata[`FLD_WHI];
         if (hitVact) frameFrontBlank_r <= pwdata[`FLD_LO];
         if (hitVact) activeFrameLines_r <= pwdata[`FLD_HI];
      end
   end

   // ==========================================================
   // Fractional divider and local start point
   // ==========================================================
   // The divider is in sixteenths; the fraction accumulates and its carry
   // stretches a period by one clock so the mean equals the divider.
   wire [7:0] dInt = div_r[`DIV_INT];
   wire [7:0] dIntEff = (dInt == 8'h00) ? 8'h01 : dInt;
   wire [4:0] fracSum = {1'b0, frac_r} + {1'b0, div_r[`DIV_FRAC]};
   wire [8:0] nextLen = {1'b0, dIntEff} + {8'h00, fracSum[4]};
   wire startPt = en_r & (cyc_r == 9'h000);
   wire periodEnd = en_r & (cyc_r >= (len_r - 9'h001));
   wire takePt = startPt & ce;

   wire [11:0] hTotM1 = (hTot_r == 12'h000) ? 12'h000 : hTot_r - 12'h001;
   wire [11:0] vTotM1 = (vTot_r == 12'h000) ? 12'h000 : vTot_r - 12'h001;
   wire hLast = (hcnt_r >= hTotM1);
   wire vLast = (vcnt_r >= vTotM1);
   wire lineStart = startPt & (hcnt_r == 12'h000);
   wire frameStart = lineStart & (vcnt_r == 12'h000);

   wire [12:0] hEnd = {1'b0, lineFrontBlank_r} + {1'b0, activeLineLen_r};
   wire [12:0] vEnd = {1'b0, frameFrontBlank_r} + {1'b0, activeFrameLines_r};
   wire hAct = (hcnt_r >= lineFrontBlank_r) & ({1'b0, hcnt_r} < hEnd);
   wire vAct = (vcnt_r >= frameFrontBlank_r) & ({1'b0, vcnt_r} < vEnd);
   assign actNow = en_r & hAct & vAct;

   always_ff @(posedge clk)
   begin
      if (reset || (ce && !en_r))
      begin
         cyc_r <= 9'h000;
         // The first period after enable already runs at the floor length.
         len_r <= reset ? 9'h001 : {1'b0, dIntEff};
         frac_r <= 4'h0;
         actPrev_r <= 1'b0;
      end
      else if (ce)
      begin
         cyc_r <= periodEnd ? 9'h000 : cyc_r + 9'h001;
         if (periodEnd)
         begin
            len_r <= nextLen;
            frac_r <= fracSum[3:0];
            actPrev_r <= actNow;
         end
      end
   end

   // ==========================================================
   // Line, frame and component counters
   // ==========================================================
   always_ff @(posedge clk)
   begin
      if (reset || (ce && !en_r))
      begin
         hcnt_r <= 12'h000;
         vcnt_r <= 12'h000;
         comp_r <= 2'h0;
      end
      else if (ce && periodEnd)
      begin
         hcnt_r <= hLast ? 12'h000 : hcnt_r + 12'h001;
         if (hLast)
         begin
            vcnt_r <= vLast ? 12'h000 : vcnt_r + 12'h001;
         end
         if (!actNow || comp_r == pixN_r)
         begin
            comp_r <= 2'h0;
         end
         else
         begin
            comp_r <= comp_r + 2'h1;
         end
      end
   end

   // Half-cycle positions since the last line and frame start points.
   wire [23:0] lh = lineStart ? 24'h00_0000 : lineHalf_r;
   wire [23:0] fh = frameStart ? 24'h00_0000 : frameHalf_r;

   always_ff @(posedge clk)
   begin
      if (reset || (ce && !en_r))
      begin
         lineHalf_r <= 24'h00_0000;
         frameHalf_r <= 24'h00_0000;
      end
      else if (ce)
      begin
         lineHalf_r <= lh + 24'h00_0002;
         frameHalf_r <= fh + 24'h00_0002;
      end
   end

   // ==========================================================
   // Control waveforms at half-cycle resolution
   // ==========================================================
   // A control is high while the half position lies in [off, off+wid).
   function automatic logic inWin(input disp_timing_pkg::half_t p,
                                  input disp_timing_pkg::half_t o,
                                  input disp_timing_pkg::half_t w);
      inWin = ({1'b0, p} >= {1'b0, o}) && ({1'b0, p} < ({1'b0, o} + {1'b0, w}));
   endfunction : inWin

   wire [23:0] ph = {14'h0000, cyc_r, 1'b0};
   logic [1:0] clkPh;
   logic [1:0] hsPh;
   logic [1:0] vsPh;
   logic [1:0] stPh;

   for (genvar k = 0; k < 2; k++)
   begin : g_ph
      // Display clock is high for the first half of each period.
      assign clkPh[k] = inWin(ph + 24'(k), 24'(clkOff_r), 24'(len_r));
      assign hsPh[k] = inWin(lh + 24'(k), 24'(hsOff_r), 24'(hsW_r));
      assign vsPh[k] = inWin(fh + 24'(k), 24'(vsOff_r), 24'(vsW_r));
      // Before the shift point the strobe still shows the prior period.
      assign stPh[k] = ((ph + 24'(k)) >= 24'(strobeShift_r)) ? actNow : actPrev_r;
   end

   always_ff @(posedge clk)
   begin
      if (reset || (ce && !en_r))
      begin
         clkPh_r <= 2'h0;
         hsPh_r <= 2'h0;
         vsPh_r <= 2'h0;
         stPh_r <= 2'h0;
      end
      else if (ce)
      begin
         clkPh_r <= clkPh;
         hsPh_r <= hsPh;
         vsPh_r <= vsPh;
         stPh_r <= stPh;
      end
   end

   assign dispClkPh = clkPh_r;
   assign lineSyncPh = hsPh_r;
   assign frameSyncPh = vsPh_r;
   assign activePixelStrobePh = stPh_r;

   // ==========================================================
   // Pixel data path
   // ==========================================================
   // A pixel word is taken on its first component; later components
   // come from the held copy. An absent word is sent as zeros.
   assign pixReady = takePt & actNow & (comp_r == 2'h0);
   wire [7:0] firstLane = pixValid ? pixIn[7:0] : 8'h00;
   wire [7:0] lane = (comp_r == 2'h0) ? firstLane : word_r[{comp_r, 3'h0} +: 8];

   always_ff @(posedge clk)
   begin
      if (reset || (ce && !en_r))
      begin
         pixelData_r <= 8'h00;
         word_r <= 32'h0000_0000;
      end
      else if (takePt)
      begin
         pixelData_r <= actNow ? lane : 8'h00;
         if (pixReady)
         begin
            word_r <= pixValid ? pixIn : 32'h0000_0000;
         end
      end
   end

   assign pixelData = pixelData_r;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_len;
      takePt |-> (len_r == {1'b0, dIntEff}) || (len_r == {1'b0, dIntEff} + 9'h001);
   endproperty
   a_len: assert property (p_len)
      else $error("Period length is not floor or floor plus one.");

   property p_cyc;
      (ce && en_r) |-> (cyc_r < len_r);
   endproperty
   a_cyc: assert property (p_cyc)
      else $error("Cycle count ran past the period.");

   property p_idle;
      (ce && !en_r) |=> (pixelData == 8'h00) && (dispClkPh == 2'h0)
         && (lineSyncPh == 2'h0) && (frameSyncPh == 2'h0);
   endproperty
   a_idle: assert property (p_idle)
      else $error("Outputs active while disabled.");

   property p_data;
      !$stable(pixelData) |-> ($past(takePt) || !$past(en_r));
   endproperty
   a_data: assert property (p_data)
      else $error("Pixel data changed away from a start point.");

   property p_strobe;
      (activePixelStrobePh != 2'h0) |-> $past(actNow || actPrev_r);
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("Strobe outside the active region.");

   property p_wrap;
      (ce && periodEnd && hLast && !vLast) |=> (hcnt_r == 12'h000)
         && (vcnt_r == $past(vcnt_r) + 12'h001);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Line wrap did not advance the line count.");

   property p_ready;
      (pixReady && pixValid) |=> (pixelData == $past(pixIn[7:0]));
   endproperty
   a_ready: assert property (p_ready)
      else $error("First component of a taken pixel not on the bus.");

   property p_front;
      pixReady |-> (hcnt_r >= lineFrontBlank_r) && (vcnt_r >= frameFrontBlank_r);
   endproperty
   a_front: assert property (p_front)
      else $error("Pixel taken inside front blanking.");

endmodule : sync_tft_display_timing_gen

// *** tft_panel_model.sv ***
// Behavioural panel that watches the phase-pair controls of the timing generator.
// Assumes each phase pair plays its first half, then its second half, of one clock cycle.
module tft_panel_model (
   input wire logic clk, // Internal clock.
   input wire logic [1:0] dispClkPh, // Display clock phases.
   input wire logic [1:0] lineSyncPh, // Line sync phases.
   input wire logic [1:0] frameSyncPh, // Frame sync phases.
   input wire logic [1:0] activePixelStrobePh, // Strobe phases.
   output int clkRise, // Half index of the last clock rise.
   output int clkPer, // Halves between clock rises.
   output int lineRise, // Half index of the last line sync rise.
   output int linePer, // Halves between line sync rises.
   output int lineWidth, // Line sync high halves.
   output int lineStrobe, // Strobe rise after line sync rise.
   output int frameRise, // Half index of the last frame sync rise.
   output int framePer, // Halves between frame sync rises.
   output int frameWidth, // Frame sync high halves.
   output int frameStrobe, // First strobe rise after frame sync rise.
   output int strobeHalves // Running count of strobe halves.
);
   timeunit 1ns;
   timeprecision 100ps;
   int half = 0;
   logic firstInFrame = 1'b0;
   logic [3:0] was = 4'h0;
   // ==========================================================
   // Edge detection, one half cycle at a time.
   always @(negedge clk)
   begin
      for (int b = 0; b < 2; b++)
      begin
         if (dispClkPh[b] && !was[0])
         begin
            clkPer = half - clkRise;
            clkRise = half;
         end
         if (lineSyncPh[b] && !was[1])
         begin
            linePer = half - lineRise;
            lineRise = half;
         end
         if (!lineSyncPh[b] && was[1])
            lineWidth = half - lineRise;
         if (frameSyncPh[b] && !was[2])
         begin
            framePer = half - frameRise;
            frameRise = half;
            firstInFrame = 1'b1;
         end
         if (!frameSyncPh[b] && was[2])
            frameWidth = half - frameRise;
         if (activePixelStrobePh[b] && !was[3])
         begin
            lineStrobe = half - lineRise;
            if (firstInFrame)
               frameStrobe = half - frameRise;
            firstInFrame = 1'b0;
         end
         if (activePixelStrobePh[b])
            strobeHalves++;
         was = {activePixelStrobePh[b], frameSyncPh[b], lineSyncPh[b], dispClkPh[b]};
         half++;
      end
   end
endmodule : tft_panel_model

// *** sync_tft_display_timing_gen_tb.sv ***
// Self-checking bench for the display timing generator.
// Assumes the panel model alongside; ce drops only in the freeze scenario.
`include "disp_timing_cfg.svh"
module sync_tft_display_timing_gen_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] pixIn = 32'h4433_2211;
   logic pixValid = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, pixReady;
   logic [7:0] pixelData;
   logic [1:0] dispClkPh, lineSyncPh, frameSyncPh, activePixelStrobePh;
   int clkRise, clkPer, lineRise, linePer, lineWidth, lineStrobe;
   int frameRise, framePer, frameWidth, frameStrobe, strobeHalves;
   int miscompares = 0;
   int totalChecks = 0;
   int cycles = 0;
   sync_tft_display_timing_gen dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pixIn(pixIn), .pixValid(pixValid),
      .pixReady(pixReady), .pixelData(pixelData), .dispClkPh(dispClkPh),
      .lineSyncPh(lineSyncPh), .frameSyncPh(frameSyncPh),
      .activePixelStrobePh(activePixelStrobePh));
   tft_panel_model panel (.clk(clk), .dispClkPh(dispClkPh), .lineSyncPh(lineSyncPh),
      .frameSyncPh(frameSyncPh), .activePixelStrobePh(activePixelStrobePh),
      .clkRise(clkRise), .clkPer(clkPer), .lineRise(lineRise), .linePer(linePer),
      .lineWidth(lineWidth), .lineStrobe(lineStrobe), .frameRise(frameRise),
      .framePer(framePer), .frameWidth(frameWidth), .frameStrobe(frameStrobe),
      .strobeHalves(strobeHalves));
   // ==========================================================
   // Shared tasks.
   task automatic end_sim;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk
   function automatic int md(input int a, input int m);
      return ((a % m) + m) % m;
   endfunction : md
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk("register", exp, q);
      chk("register error", 32'h0, e);
   endtask : rd
   task automatic wait_ev(input int sel);
      int last;
      int n;
      last = sel ? frameRise : clkRise;
      n = 0;
      while ((sel ? frameRise : clkRise) == last && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ev
   task automatic wait_pix;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (pixReady !== 1'b1 && n < 2000);
   endtask : wait_pix
   // ==========================================================
   // Scenarios.
   task automatic test_reset;
      logic [7:0] offs [10];
      logic [31:0] vals [10];
      logic [31:0] q;
      logic e;
      offs = '{`OFF_CTRL, `OFF_DIV, `OFF_PIX, `OFF_HTOT, `OFF_HSYNC, `OFF_HACT, `OFF_VTOT,
               `OFF_VSYNC, `OFF_VACT, `OFF_SHIFT};
      vals = '{32'h0, {4'h0, `RST_RATIO, 4'h0, `RST_DIVIDE}, {30'h0, `RST_PIXN},
               {20'h0, `RST_HTOT}, {4'h0, `RST_HSOFF, 4'h0, `RST_HSW},
               {4'h0, `RST_HLEN, 4'h0, `RST_HFRONT}, {20'h0, `RST_VTOT}, {`RST_VSOFF, `RST_VSW},
               {4'h0, `RST_VLEN, 4'h0, `RST_VFRONT}, {8'h0, `RST_SHIFT, 8'h0, `RST_CLKOFF}};
      for (int i = 0; i < 10; i++)
         rd(offs[i], vals[i]);
      apb(1'b1, 8'h30, 32'hffff_ffff, q, e);
      chk("write error", 32'h1, e);
      apb(1'b0, 8'h30, 32'h0, q, e);
      chk("read error", 32'h1, e);
      chk("unmapped data", 32'h0, q);
      wr(`OFF_DIV, 32'h0abc_0028);
      rd(`OFF_DIV, 32'h0abc_0028);
      repeat (20)
      begin
         @(negedge clk);
         chk("idle outputs", 32'h0, {dispClkPh, lineSyncPh, frameSyncPh, pixelData});
      end
   endtask : test_reset
   task automatic test_divider;
      int s;
      wr(`OFF_CTRL, 32'h1);
      repeat (3) wait_ev(0);
      s = clkRise;
      repeat (8)
      begin
         wait_ev(0);
         chk("clock period", 32'h1, clkPer == 4 || clkPer == 6);
         chk("clock edge half", 32'h0, md(clkRise, 2));
      end
      chk("eight periods", 32'd40, clkRise - s);
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_SHIFT, 32'h0000_0001);
      wr(`OFF_CTRL, 32'h1);
      repeat (3) wait_ev(0);
      repeat (4)
      begin
         wait_ev(0);
         chk("shifted clock half", 32'h1, md(clkRise, 2));
      end
   endtask : test_divider
   task automatic test_frame;
      int s;
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_DIV, 32'h0000_0020);
      wr(`OFF_SHIFT, 32'h0);
      wr(`OFF_HTOT, 32'h0000_000a);
      wr(`OFF_HSYNC, 32'h0001_0003);
      wr(`OFF_HACT, 32'h0006_0002);
      wr(`OFF_VTOT, 32'h0000_0004);
      wr(`OFF_VSYNC, 32'h0002_0005);
      wr(`OFF_VACT, 32'h0002_0001);
      wr(`OFF_CTRL, 32'h1);
      repeat (2) wait_ev(1);
      s = strobeHalves;
      wait_ev(1);
      chk("frame period", 32'd160, framePer);
      chk("frame width", 32'd5, frameWidth);
      chk("line period", 32'd40, linePer);
      chk("line width", 32'd3, lineWidth);
      chk("line offset", 32'd1, md(lineRise - clkRise, 4));
      chk("frame offset", 32'd1, md(frameRise - lineRise, 40));
      chk("strobe in line", 32'd7, lineStrobe);
      chk("strobe in frame", 32'd46, frameStrobe);
      chk("strobe halves", 32'd48, strobeHalves - s);
      wr(`OFF_SHIFT, 32'h0001_0000);
      repeat (2) wait_ev(1);
      chk("shifted strobe", 32'd8, lineStrobe);
   endtask : test_frame
   task automatic test_pixels;
      logic [31:0] w;
      wr(`OFF_PIX, 32'h1);
      pixValid <= 1'b1;
      wait_ev(1);
      repeat (4)
      begin
         wait_pix;
         w = pixIn;
         @(posedge clk);
         pixIn <= pixIn + 32'h0101_0101;
         @(negedge clk);
         chk("first component", {24'h0, w[7:0]}, {24'h0, pixelData});
         repeat (2) @(negedge clk);
         chk("second component", {24'h0, w[15:8]}, {24'h0, pixelData});
      end
      @(posedge clk);
      pixValid <= 1'b0;
      wait_pix;
      @(negedge clk);
      chk("empty pixel", 32'h0, {24'h0, pixelData});
   endtask : test_pixels
   task automatic test_freeze;
      logic [13:0] held;
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      held = {dispClkPh, lineSyncPh, frameSyncPh, pixelData};
      repeat (5)
      begin
         @(negedge clk);
         chk("frozen outputs", {18'h0, held},
             {18'h0, dispClkPh, lineSyncPh, frameSyncPh, pixelData});
         chk("stalled ready", 32'h0, {31'h0, pready});
      end
      @(posedge clk);
      ce <= 1'b1;
   endtask : test_freeze
   // ==========================================================
   // Clock, main sequence and timeout.
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      test_reset;
      test_divider;
      test_frame;
      test_pixels;
      test_freeze;
      end_sim;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         end_sim;
      end
   end
endmodule : sync_tft_display_timing_gen_tb
